//--- hdl/sbs_pkg.sv
// Shared constants, types and burst function of the burst SRAM control
`default_nettype none
package sbs_pkg;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int SLEEP_ENTRY_CYCLES = 2;
  localparam int SLEEP_RECOVERY_CYCLES = 2;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] BURST_FIRST = 2'h0;
  // Pin sync order: sleep, output drive n, flow select n, linear order n
  localparam int PIN_SLEEP = 3;
  localparam int PIN_DRIVE_N = 2;
  localparam int PIN_FLOW_N = 1;
  localparam int PIN_LINEAR_N = 0;
  localparam logic [3:0] PIN_SYNC_RST = 4'h6;
  localparam logic [1:0] SLEEP_CNT_RST = 2'h0;

  typedef enum logic [1:0] {SBS_DESEL, SBS_READ, SBS_WRITE} sbs_state_t;

  function automatic logic [1:0] sbs_burst_low(input logic [1:0] start,
                                               input logic [1:0] count,
                                               input logic interleave);
    if (interleave)
      sbs_burst_low = start ^ count;
    else
      sbs_burst_low = 2'(start + count);
  endfunction : sbs_burst_low
endpackage : sbs_pkg
`default_nettype wire

//--- hdl/sbs_sram_control.sv
// Burst SRAM control: command decode, burst counter, data pipes, sleep
// Behaviour
// - Load edge, store strobe high, all selects active: latch address, start read burst.
// - Advance high continues burst on counter address, keeping the burst type.
// - Load edge, store low, some lane strobe low, selects active: start write burst.
// - Store low with no lane strobe: no write happens, bus stays undriven.
// - Load edge with any select inactive deselects with outputs off.
// - Load edge, selects active, store low, no lanes: deselect cycle.
// - Continue edges after a deselect keep the device deselected.
// - Clock gate high: edge ignored, address and state held.
// - Gate high keeps pipelined read data driven, write bus stays off.
// - Output drive disabled: read still done, pins stay undriven.
// - Drivers switch off during writes whatever the output drive input.
// - All outputs undriven from power-up.
// - Two-bit counter clears to zero on load, steps on every continue except when deselected.
// - Counter returns to its loaded value after four addresses.
// - Linear order steps low address bits by binary increment.
// - Interleaved order XORs start bits with the burst count.
// - Flow select low gives flow-through, high or open gives pipeline.
// - Sleep request low or open is active operation, high is standby.
// - Sleep request asynchronous; sleep entered after two cycles, state kept.
// - Asleep: deselected, inputs ignored, outputs off; wake two cycles after release.
// - Pipelined read data appears on the pins after the second edge.
// - Each lane strobe enables writing of one nine-bit lane.
`default_nettype none
module sbs_sram_control
  import sbs_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic clock,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic advance_load,
  input wire logic store_n,
  input wire logic [LANES-1:0] byte_lane_strobe_n,
  input wire logic chip_select_one_n,
  input wire logic chip_select_two,
  input wire logic chip_select_three_n,
  input wire logic clock_gate_n,
  input wire logic out_drive_n,
  input wire logic sleep_request,
  input wire logic flow_select_n,
  input wire logic linear_order_n,
  input wire logic [LANES*LANE_W-1:0] data_in,
  output logic [LANES*LANE_W-1:0] data_out,
  output logic [LANES-1:0] data_oe
);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int DW = LANES * LANE_W;

  logic [DW-1:0] mem [DEPTH];
  logic [3:0] pin_s1_ff;
  logic [3:0] pin_s2_ff;
  logic asleep_ff;
  logic [1:0] sleep_cnt_ff;
  sbs_state_t state_ff;
  sbs_state_t nxt_state;
  logic [ADDR_W-1:0] base_ff;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  logic [DW-1:0] rd_stage_ff;
  logic rd_stage_v_ff;
  logic drive_ff;
  logic nxt_drive;
  logic [DW-1:0] data_out_ff;
  logic [LANES-1:0] data_oe_ff;
  logic [ADDR_W-1:0] wr1_addr_ff;
  logic [ADDR_W-1:0] wr2_addr_ff;
  logic [LANES-1:0] wr1_lanes_ff;
  logic [LANES-1:0] wr2_lanes_ff;
  logic wr1_v_ff;
  logic wr2_v_ff;

  logic active;
  logic load;
  logic selected;
  logic any_lane;
  logic flow_mode;
  logic interleave;
  logic drive_n_s;
  logic issue_read;
  logic issue_write;
  logic [ADDR_W-1:0] acc_addr;
  logic [1:0] cont_low;
  logic commit_v;
  logic [ADDR_W-1:0] commit_addr;
  logic [LANES-1:0] commit_lanes;

  // Asynchronous and mode pins; reset defaults mimic the pull devices
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      pin_s1_ff <= PIN_SYNC_RST;
      pin_s2_ff <= PIN_SYNC_RST;
    end
    else
    begin
      pin_s1_ff <= {sleep_request, out_drive_n, flow_select_n, linear_order_n};
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign flow_mode = !pin_s2_ff[PIN_FLOW_N];
  assign interleave = pin_s2_ff[PIN_LINEAR_N];
  assign drive_n_s = pin_s2_ff[PIN_DRIVE_N];

  // Sleep entry and wake, each after a fixed number of cycles
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      asleep_ff <= 1'b0;
      sleep_cnt_ff <= SLEEP_CNT_RST;
    end
    else if (pin_s2_ff[PIN_SLEEP] != asleep_ff)
    begin
      if (int'(sleep_cnt_ff) == (asleep_ff ? SLEEP_RECOVERY_CYCLES : SLEEP_ENTRY_CYCLES) - 1)
      begin
        asleep_ff <= !asleep_ff;
        sleep_cnt_ff <= SLEEP_CNT_RST;
      end
      else
        sleep_cnt_ff <= 2'(sleep_cnt_ff + 2'h1);
    end
    else
      sleep_cnt_ff <= SLEEP_CNT_RST;
  end

  // Command decode
  assign active = !asleep_ff && !clock_gate_n;
  assign load = !advance_load;
  assign selected = !chip_select_one_n && chip_select_two && !chip_select_three_n;
  assign any_lane = !(&byte_lane_strobe_n);
  assign nxt_cnt = 2'(cnt_ff + BURST_STEP);
  assign cont_low = sbs_burst_low(base_ff[1:0], nxt_cnt, interleave);
  assign acc_addr = load ? address : {base_ff[ADDR_W-1:2], cont_low};

  always_comb
  begin
    nxt_state = state_ff;
    if (load)
    begin
      if (!selected)
        nxt_state = SBS_DESEL;
      else if (store_n)
        nxt_state = SBS_READ;
      else if (any_lane)
        nxt_state = SBS_WRITE;
      else
        nxt_state = SBS_DESEL;
    end
  end

  // A continue keeps the current type, deselect included
  assign issue_read = active && (load ? (nxt_state == SBS_READ) : (state_ff == SBS_READ));
  assign issue_write = active && (load ? (nxt_state == SBS_WRITE) : (state_ff == SBS_WRITE));

  always_ff @(posedge clock)
  begin
    if (reset)
      state_ff <= SBS_DESEL;
    else if (active)
      state_ff <= nxt_state;
  end

  // Burst base and counter
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      base_ff <= '0;
      cnt_ff <= BURST_FIRST;
    end
    else if (active && load)
    begin
      base_ff <= address;
      cnt_ff <= BURST_FIRST;
    end
    else if (active && state_ff != SBS_DESEL)
      cnt_ff <= nxt_cnt;
  end

  // Read path: flow-through skips the staging register
  assign nxt_drive = flow_mode ? issue_read : rd_stage_v_ff;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rd_stage_ff <= '0;
      rd_stage_v_ff <= 1'b0;
      drive_ff <= 1'b0;
      data_out_ff <= '0;
    end
    else if (active)
    begin
      rd_stage_ff <= mem[acc_addr];
      rd_stage_v_ff <= issue_read;
      drive_ff <= nxt_drive;
      data_out_ff <= flow_mode ? mem[acc_addr] : rd_stage_ff;
    end
  end

  // Pin drive follows read data, output drive input and sleep
  always_ff @(posedge clock)
  begin
    if (reset)
      data_oe_ff <= '0;
    else if (asleep_ff || drive_n_s)
      data_oe_ff <= '0;
    else if (active)
      data_oe_ff <= {LANES{nxt_drive}};
    else
      data_oe_ff <= {LANES{drive_ff}};
  end

  // Late write pipeline, one stage shorter in flow-through
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr1_v_ff <= 1'b0;
      wr2_v_ff <= 1'b0;
      wr1_addr_ff <= '0;
      wr2_addr_ff <= '0;
      wr1_lanes_ff <= '0;
      wr2_lanes_ff <= '0;
    end
    else if (active)
    begin
      wr1_v_ff <= issue_write;
      wr1_addr_ff <= acc_addr;
      wr1_lanes_ff <= issue_write ? ~byte_lane_strobe_n : '0;
      wr2_v_ff <= wr1_v_ff;
      wr2_addr_ff <= wr1_addr_ff;
      wr2_lanes_ff <= wr1_lanes_ff;
    end
  end

  assign commit_v = active && (flow_mode ? wr1_v_ff : wr2_v_ff);
  assign commit_addr = flow_mode ? wr1_addr_ff : wr2_addr_ff;
  assign commit_lanes = flow_mode ? wr1_lanes_ff : wr2_lanes_ff;

  always_ff @(posedge clock)
  begin
    if (commit_v)
    begin
      for (int i = 0; i < LANES; i++)
      begin
        if (commit_lanes[i])
          mem[commit_addr][i*LANE_W +: LANE_W] <= data_in[i*LANE_W +: LANE_W];
      end
    end
  end

  assign data_out = data_out_ff;
  assign data_oe = data_oe_ff;

  // Checks
  sequence s_pipe_read;
    active && issue_read && !flow_mode && !drive_n_s ##1 active && !drive_n_s;
  endsequence

  sequence s_four_steps;
    (active && !load && state_ff != SBS_DESEL)[*4];
  endsequence

  a_read_start: assert property (@(posedge clock) disable iff (reset)
    active && load && selected && store_n |=> state_ff == SBS_READ && base_ff == $past(address))
    else $error("read burst not started");
  a_write_start: assert property (@(posedge clock) disable iff (reset)
    active && load && selected && !store_n && any_lane |=> state_ff == SBS_WRITE)
    else $error("write burst not started");
  a_burst_type: assert property (@(posedge clock) disable iff (reset)
    active && !load |=> state_ff == $past(state_ff))
    else $error("burst type changed on continue");
  a_unselect_load: assert property (@(posedge clock) disable iff (reset)
    active && load && !selected |=> state_ff == SBS_DESEL ##1 data_oe_ff == '0 || rd_stage_v_ff)
    else $error("no deselect on load");
  a_no_lane_load: assert property (@(posedge clock) disable iff (reset)
    active && load && selected && !store_n && !any_lane |=> state_ff == SBS_DESEL && !wr1_v_ff)
    else $error("empty write load not deselect");
  a_abort_nowrite: assert property (@(posedge clock) disable iff (reset)
    active && !load && state_ff == SBS_WRITE && !any_lane |=> wr1_lanes_ff == '0)
    else $error("write abort wrote lanes");
  a_desel_stays: assert property (@(posedge clock) disable iff (reset)
    active && !load && state_ff == SBS_DESEL |=> state_ff == SBS_DESEL)
    else $error("deselect continue left deselect");
  a_stall_hold: assert property (@(posedge clock) disable iff (reset)
    !active |=> $stable(cnt_ff) && $stable(base_ff) && $stable(state_ff))
    else $error("state moved on ignored edge");
  a_stall_drive: assert property (@(posedge clock) disable iff (reset)
    clock_gate_n && !asleep_ff && drive_ff && !drive_n_s |=> data_oe_ff == '1)
    else $error("stalled read stopped driving");
  a_drive_gate: assert property (@(posedge clock) disable iff (reset)
    drive_n_s |=> data_oe_ff == '0)
    else $error("pins driven while output drive off");
  a_write_quiet: assert property (@(posedge clock) disable iff (reset)
    active && issue_write && flow_mode |=> data_oe_ff == '0)
    else $error("pins driven during write");
  a_reset_quiet: assert property (@(posedge clock)
    reset |=> data_oe_ff == '0)
    else $error("pins driven after reset");
  a_count_step: assert property (@(posedge clock) disable iff (reset)
    active && !load && state_ff != SBS_DESEL |=> cnt_ff == 2'($past(cnt_ff) + 2'h1))
    else $error("counter did not step");
  a_count_wrap: assert property (@(posedge clock) disable iff (reset)
    s_four_steps |=> cnt_ff == $past(cnt_ff, 4))
    else $error("counter did not wrap after four");
  a_linear_addr: assert property (@(posedge clock) disable iff (reset)
    issue_write && !load && !interleave
    |=> wr1_addr_ff[1:0] == 2'($past(base_ff[1:0]) + $past(cnt_ff) + 2'h1))
    else $error("linear burst address wrong");
  a_interleave_addr: assert property (@(posedge clock) disable iff (reset)
    issue_write && !load && interleave
    |=> wr1_addr_ff[1:0] == ($past(base_ff[1:0]) ^ 2'($past(cnt_ff) + 2'h1)))
    else $error("interleaved burst address wrong");
  a_sleep_entry: assert property (@(posedge clock) disable iff (reset)
    !asleep_ff && pin_s2_ff[PIN_SLEEP] ##1 pin_s2_ff[PIN_SLEEP] |=> asleep_ff)
    else $error("sleep not entered after two cycles");
  a_sleep_wake: assert property (@(posedge clock) disable iff (reset)
    asleep_ff && !pin_s2_ff[PIN_SLEEP] ##1 !pin_s2_ff[PIN_SLEEP] |=> !asleep_ff)
    else $error("no wake after two cycles");
  a_sleep_quiet: assert property (@(posedge clock) disable iff (reset)
    asleep_ff |=> data_oe_ff == '0 && $stable(state_ff))
    else $error("activity while asleep");
  a_pipe_latency: assert property (@(posedge clock) disable iff (reset)
    s_pipe_read |=> data_oe_ff == '1)
    else $error("pipelined read not driven at second edge");
  a_flow_latency: assert property (@(posedge clock) disable iff (reset)
    active && issue_read && flow_mode && !drive_n_s |=> data_oe_ff == '1)
    else $error("flow read not driven next cycle");
endmodule : sbs_sram_control
`default_nettype wire

//--- sim/sbs_ctrl_model.sv
// Controller-side write data model for the burst SRAM control
`default_nettype none
module sbs_ctrl_model
  import sbs_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_gate_n,
  input wire logic flow_select_n,
  input wire logic advance_load,
  input wire logic store_n,
  input wire logic [LANES-1:0] byte_lane_strobe_n,
  input wire logic selected,
  input wire logic [LANES*LANE_W-1:0] word,
  output var logic [LANES*LANE_W-1:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic write_ff;
  logic [1:0] due_ff;
  logic [LANES*LANE_W-1:0] word0_ff;
  logic [LANES*LANE_W-1:0] word1_ff;
  logic [LANES*LANE_W-1:0] last_ff;
  logic take_write;
  logic give;
  // Write type follows the burst start
  assign take_write = advance_load ? write_ff : selected & ~store_n & ~&byte_lane_strobe_n;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      write_ff <= 1'b0;
      due_ff <= 2'h0;
    end
    else if (!clock_gate_n)
    begin
      write_ff <= take_write;
      due_ff <= {due_ff[0], take_write};
      word0_ff <= word;
      word1_ff <= word0_ff;
    end
  end
  // Data one acting edge late in flow-through, two in pipeline
  assign give = flow_select_n ? due_ff[1] : due_ff[0];
  always_ff @(posedge clock)
  begin
    if (reset)
      last_ff <= '0;
    else
      last_ff <= data_in;
  end
  // Idle bus shows a changing pattern
  assign data_in = give ? (flow_select_n ? word1_ff : word0_ff) : ~last_ff;
endmodule : sbs_ctrl_model
`default_nettype wire

//--- sim/sbs_sram_control_bench.sv
// Testbench for the burst SRAM control
`default_nettype none
module sbs_sram_control_bench
  import sbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock;
  logic reset;
  logic [3:0] address;
  logic advance_load;
  logic store_n;
  logic [LANES-1:0] byte_lane_strobe_n;
  logic chip_select_one_n;
  logic chip_select_two;
  logic chip_select_three_n;
  logic clock_gate_n;
  logic out_drive_n;
  logic sleep_request;
  logic flow_select_n;
  logic linear_order_n;
  logic [LANES*LANE_W-1:0] data_in;
  logic [LANES*LANE_W-1:0] data_out;
  logic [LANES-1:0] data_oe;
  logic [LANES*LANE_W-1:0] word;
  logic [4:0] salt;
  logic [LANES*LANE_W-1:0] ref_mem [16];
  int fail_count;
  int n_checks;
  wire logic selected = !chip_select_one_n && chip_select_two && !chip_select_three_n;

  sbs_sram_control #(.ADDR_W(4)) i_sbs_sram_control (.clock(clock), .reset(reset),
    .address(address), .advance_load(advance_load), .store_n(store_n),
    .byte_lane_strobe_n(byte_lane_strobe_n), .chip_select_one_n(chip_select_one_n),
    .chip_select_two(chip_select_two), .chip_select_three_n(chip_select_three_n),
    .clock_gate_n(clock_gate_n), .out_drive_n(out_drive_n), .sleep_request(sleep_request),
    .flow_select_n(flow_select_n), .linear_order_n(linear_order_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe));
  sbs_ctrl_model i_sbs_ctrl_model (.clock(clock), .reset(reset), .clock_gate_n(clock_gate_n),
    .flow_select_n(flow_select_n), .advance_load(advance_load), .store_n(store_n),
    .byte_lane_strobe_n(byte_lane_strobe_n), .selected(selected), .word(word),
    .data_in(data_in));

  always #20 clock = ~clock;

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Burst of beats from a, one edge stalled at iteration stall, then deselects
  task automatic run(input logic wr, input logic [3:0] a, input int beats,
                     input logic [3:0] ln, input int stall);
    int k;
    int b;
    int j;
    int lat;
    logic [3:0] ab;
    logic [3:0] ad;
    logic rd;
    logic [3:0] lb;
    lat = flow_select_n ? 2 : 1;
    for (k = 0; k <= beats + lat + 3; k++)
    begin
      @(posedge clock);
      b = k - (k > stall);
      clock_gate_n <= (k == stall);
      ab = {a[3:2], linear_order_n ? a[1:0] ^ 2'(b) : 2'(a[1:0] + 2'(b))};
      address <= (b == 0) ? a : ~a;
      // Partial-lane burst ends with a write abort beat
      lb = (wr && ln == 4'hE && b == 2) ? 4'hF : ln;
      if (b < beats)
      begin
        advance_load <= (b != 0);
        store_n <= !wr;
        byte_lane_strobe_n <= lb;
        {chip_select_one_n, chip_select_two, chip_select_three_n} <= 3'h2;
        word <= {4{salt, ab}};
        for (int i = 0; i < LANES; i++)
          if (wr && !lb[i])
            ref_mem[ab][9*i +: 9] = {salt, ab};
      end
      else
      begin
        advance_load <= 1'b0;
        store_n <= 1'b1;
        {chip_select_one_n, chip_select_two, chip_select_three_n} <= {salt == 1, salt != 2, salt > 2};
      end
      #1;
      j = k - (k > stall) - lat;
      ad = {a[3:2], linear_order_n ? a[1:0] ^ 2'(j) : 2'(a[1:0] + 2'(j))};
      rd = (j >= 0) && (j < beats) && !wr && !out_drive_n;
      check("lane drive", 36'(data_oe), rd ? 36'hF : 36'h0);
      if (rd)
        check("read data", data_out, ref_mem[ad]);
    end
  endtask : run

  task automatic sleep_test;
    @(posedge clock);
    sleep_request <= 1'b1;
    repeat (6) @(posedge clock);
    address <= 4'h5;
    {chip_select_one_n, chip_select_two, chip_select_three_n} <= 3'h2;
    repeat (4)
    begin
      @(posedge clock);
      #1;
      check("asleep drive", 36'(data_oe), 36'h0);
    end
    @(posedge clock);
    sleep_request <= 1'b0;
    chip_select_one_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : sleep_test

  initial
  begin
    clock = 1'b0;
    reset = 1'b1;
    address = 4'h0;
    advance_load = 1'b0;
    store_n = 1'b1;
    byte_lane_strobe_n = 4'hF;
    {chip_select_one_n, chip_select_two, chip_select_three_n} = 3'h6;
    {clock_gate_n, out_drive_n, sleep_request, flow_select_n, linear_order_n} = 5'h2;
    word = 36'h0;
    salt = 5'h1;
    repeat (4) @(posedge clock);
    #1;
    check("reset drive", 36'(data_oe), 36'h0);
    @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    run(1'b1, 4'h5, 4, 4'h0, 99);
    run(1'b0, 4'h5, 5, 4'h0, 99);
    run(1'b0, 4'h6, 4, 4'h0, 2);
    salt = 5'h2;
    run(1'b1, 4'h5, 3, 4'hE, 1);
    salt = 5'h3;
    run(1'b1, 4'h5, 2, 4'hF, 99);
    run(1'b0, 4'h5, 4, 4'h0, 99);
    out_drive_n <= 1'b1;
    repeat (3) @(posedge clock);
    run(1'b0, 4'h4, 2, 4'h0, 99);
    out_drive_n <= 1'b0;
    linear_order_n <= 1'b1;
    salt = 5'h4;
    repeat (4) @(posedge clock);
    run(1'b1, 4'h9, 4, 4'h0, 99);
    run(1'b0, 4'hB, 4, 4'h0, 99);
    linear_order_n <= 1'b0;
    flow_select_n <= 1'b0;
    salt = 5'h5;
    repeat (4) @(posedge clock);
    run(1'b1, 4'h2, 4, 4'h0, 99);
    run(1'b0, 4'h3, 4, 4'h0, 1);
    sleep_test();
    run(1'b0, 4'h3, 4, 4'h0, 99);
    wrap_up();
  end

  initial
  begin
    #200000;
    fail_count++;
    wrap_up();
  end
endmodule : sbs_sram_control_bench
`default_nettype wire
